// >>> rxfs_pkg.sv
// Package for the receive frame filter and status block.
// Holds register offsets, bit positions, limits and the carrier structs.
package rxfs_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [11:0] RXFS_OFS_FILTER = 12'h00c; // Write: config
   localparam logic [11:0] RXFS_OFS_RESULT = 12'h00c; // Read: status
   localparam logic [11:0] RXFS_OFS_ADDR_LO = 12'h010; // Station bytes 0-3
   localparam logic [11:0] RXFS_OFS_ADDR_HI = 12'h014; // Station bytes 4-5
   localparam logic [11:0] RXFS_OFS_HASH_LO = 12'h018; // Hash bits 31:0
   localparam logic [11:0] RXFS_OFS_HASH_HI = 12'h01c; // Hash bits 63:32
   localparam logic [11:0] RXFS_OFS_TALLY = 12'h020; // Three tallies
   localparam logic [11:0] RXFS_OFS_PAGE = 12'h024; // Page select bits

   // ----------------------------------------------------------------
   // Config bit positions
   // ----------------------------------------------------------------
   localparam int RXFS_CFG_KEEP_BAD = 0;
   localparam int RXFS_CFG_SHORT = 1;
   localparam int RXFS_CFG_ALL_ONES = 2;
   localparam int RXFS_CFG_GROUP = 3;
   localparam int RXFS_CFG_ANY_UNI = 4;
   localparam int RXFS_CFG_OBSERVE = 5;
   localparam logic [7:0] RXFS_CFG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int RXFS_ST_OK = 0;
   localparam int RXFS_ST_CSUM = 1;
   localparam int RXFS_ST_MISALIGN = 2;
   localparam int RXFS_ST_OVERFLOW = 3;
   localparam int RXFS_ST_DROPPED = 4;
   localparam int RXFS_ST_GROUP = 5;
   localparam int RXFS_ST_RX_OFF = 6;
   localparam int RXFS_ST_DEFER = 7;

   // ----------------------------------------------------------------
   // Frame limits
   // ----------------------------------------------------------------
   localparam logic [15:0] RXFS_MIN_LEN = 16'h0040; // 64 bytes
   localparam logic [15:0] RXFS_RUNT_LEN = 16'h0008; // 8 bytes
   localparam logic [2:0] RXFS_DRIBBLE_MAX = 3'h4; // Fewer than 5
   localparam logic [2:0] RXFS_DA_LAST = 3'h5; // Sixth address byte
   localparam logic [1:0] RXFS_PAGE_ZERO = 2'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Decoded byte stream from the line decoder
   typedef struct packed {
      logic start; // Frame start pulse
      logic valid; // Data byte pulse
      logic [7:0] data; // Byte, first bit in bit 0
      logic done; // Frame end pulse
      logic [2:0] dribble; // Bits past last byte boundary
      logic csum_bad_end; // Checksum bad at frame end
      logic csum_bad_byte; // Checksum bad at last boundary
      logic fifo_over; // Receive FIFO overflow pulse
      logic no_buffer; // No receive buffer left
   } rxfs_stream_t;

   // Result towards the local DMA
   typedef struct packed {
      logic take; // Frame accepted for buffering
      logic reject; // Frame dropped, buffer rewinds
      logic stat_wr; // Write status byte at head
      logic [7:0] stat; // Status byte
   } rxfs_dma_t;

   // Tally increment pulses
   typedef struct packed {
      logic misalign;
      logic checksum;
      logic dropped;
   } rxfs_tally_t;

endpackage

// >>> rxfs_tally.sv
// One 8-bit error tally counter for the receive filter block.
// Assumes the increment is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module rxfs_tally (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Control
   input wire logic inc_i,
   input wire logic clr_i,
   // Count
   output logic [7:0] count_o
);
   // ----------------------------------------------------------------
   // Counter state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
   } rxfs_tally_st_t;

   rxfs_tally_st_t st_ff; // Registered state
   rxfs_tally_st_t nxt_st; // Next state

   // Saturates so a busy net never wraps a tally back to small values
   always_comb begin
      nxt_st = st_ff;
      if (clr_i) begin
         // An event in the clearing cycle is still counted
         nxt_st.count = {7'h00, inc_i};
      end else if (inc_i && st_ff.count != 8'hff) begin
         nxt_st.count = st_ff.count + 8'h01;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count_o = st_ff.count;
endmodule

// >>> rxfs_filter.sv
// Receive frame acceptance filter and per-frame status for the
// network controller receive path.
// Assumes a decoded byte stream on clk_i and an APB master for software.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module rxfs_filter
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Receive stream from the line decoder
   input wire rxfs_pkg::rxfs_stream_t rx_i,
   // Line pins, asynchronous
   input wire logic carrier_present_input_i,
   input wire logic collision_line_i,
   // Result to the local DMA
   output rxfs_pkg::rxfs_dma_t dma_o
);
   import rxfs_pkg::*;

   // ----------------------------------------------------------------
   // Frame states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RXFS_IDLE = 2'b00,
      RXFS_DEST = 2'b01,
      RXFS_BODY = 2'b11,
      RXFS_DROP = 2'b10
   } rxfs_fsm_t;

   // ----------------------------------------------------------------
   // All block state except the tally counts
   // ----------------------------------------------------------------
   typedef struct packed {
      rxfs_fsm_t fsm; // Frame sequencer
      logic [7:0] cfg; // Filter config
      logic [47:0] station; // Station address, byte 0 low
      logic [63:0] hash; // Group hash array
      logic [1:0] page; // Page select hi/lo
      logic [7:0] result; // Receive status
      logic [2:0] da_idx; // Destination byte index
      logic [47:0] da; // Captured destination
      logic [5:0] crc_idx; // Hash index being built
      logic [31:0] crc; // Running destination checksum
      logic [15:0] len; // Byte count
      logic accept; // Frame passed the filter
      logic recognised; // Address matched
      logic [31:0] rdata; // APB read data
      logic ready; // APB ready
      logic slverr; // APB error
      rxfs_dma_t dma; // DMA result
      rxfs_tally_t tinc; // Tally pulses
      logic [1:0] car_sync; // Carrier synchroniser
      logic [1:0] col_sync; // Collision synchroniser
   } rxfs_state_t;

   rxfs_state_t st_ff; // Registered state
   rxfs_state_t nxt_st; // Next state

   logic [7:0] misalign_cnt; // Tally outputs
   logic [7:0] checksum_cnt;
   logic [7:0] dropped_cnt;
   logic tally_clr; // Software clear of tallies

   // ----------------------------------------------------------------
   // Tally counters
   // ----------------------------------------------------------------
   // misalign tally
   rxfs_tally u_misalign (
      .clk_i(clk_i), .rstn_i(rstn_i),
      .inc_i(st_ff.tinc.misalign), .clr_i(tally_clr),
      .count_o(misalign_cnt));
   rxfs_tally u_checksum (
      .clk_i(clk_i), .rstn_i(rstn_i),
      .inc_i(st_ff.tinc.checksum), .clr_i(tally_clr),
      .count_o(checksum_cnt));
   rxfs_tally u_dropped (
      .clk_i(clk_i), .rstn_i(rstn_i),
      .inc_i(st_ff.tinc.dropped), .clr_i(tally_clr),
      .count_o(dropped_cnt));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One checksum step over a byte, LSB first, reflected polynomial
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         // Fold in the polynomial when the out-shifted bit differs
         r = (r >> 1) ^ ((r[0] ^ d[i]) ? 32'hedb88320 : 32'h00000000);
      end
      return r;
   endfunction
   logic apb_acc; // Access phase
   logic apb_wr; // Write taken this edge
   logic apb_rd; // Read taken this edge
   logic page0; // Page zero selected
   logic [7:0] byte_in; // Current stream byte
   logic [31:0] crc_new; // Checksum after this byte
   logic is_group; // Group bit of destination
   logic is_bcast; // All-ones destination
   logic hash_hit; // Hash array hit
   logic uni_hit; // Unicast category match
   logic grp_hit; // Group or broadcast match
   logic bad_csum; // Checksum error at end
   logic misalign; // Alignment error at end
   logic len_bad; // Length rejected
   logic err_rej; // Error rejected
   logic dropped; // Recognised frame dropped for lack of room or in observe mode
   logic [7:0] fin_stat; // Final status byte

   assign apb_acc = psel_i && penable_i;
   assign apb_wr = apb_acc && pwrite_i && !st_ff.ready;
   assign apb_rd = apb_acc && !pwrite_i && !st_ff.ready;
   assign page0 = (st_ff.page == RXFS_PAGE_ZERO);
   assign tally_clr = apb_wr && paddr_i == RXFS_OFS_TALLY && pstrb_i[0];
   assign byte_in = rx_i.data;
   assign crc_new = crc_byte(st_ff.crc, byte_in);
   // misaligned when more than 4 dribble bits and boundary checksum bad
   assign misalign = (rx_i.dribble > RXFS_DRIBBLE_MAX) &&
                     rx_i.csum_bad_byte;
   assign bad_csum = (rx_i.csum_bad_end &&
                      rx_i.dribble <= RXFS_DRIBBLE_MAX) || misalign;
   // runts below 8 always go, 8..63 only when allowed
   assign len_bad = (st_ff.len < RXFS_MIN_LEN) &&
                    (!st_ff.cfg[RXFS_CFG_SHORT] ||
                     st_ff.len < RXFS_RUNT_LEN);
   assign err_rej = len_bad ||
                    (bad_csum && !st_ff.cfg[RXFS_CFG_KEEP_BAD]);
   // no buffer or observe mode drops a recognised frame
   assign dropped = st_ff.recognised &&
                    (rx_i.no_buffer || st_ff.cfg[RXFS_CFG_OBSERVE]);

   // Destination classification with the final byte folded in
   always_comb begin
      logic [47:0] da_full;
      logic [31:0] c;
      da_full = st_ff.da;
      da_full[47:40] = byte_in;
      c = crc_new;
      is_group = da_full[0];
      is_bcast = (da_full == 48'hffffffffffff);
      // Hash index from top six checksum bits
      hash_hit = st_ff.hash[{c[26], c[27], c[28], c[29], c[30], c[31]}];
      uni_hit = !is_group && (st_ff.cfg[RXFS_CFG_ANY_UNI] ||
                              da_full == st_ff.station);
      grp_hit = is_group &&
                ((is_bcast && st_ff.cfg[RXFS_CFG_ALL_ONES]) ||
                 (!is_bcast && st_ff.cfg[RXFS_CFG_GROUP] && hash_hit));
   end

   // Final status assembly
   always_comb begin
      fin_stat = st_ff.result;
      fin_stat[RXFS_ST_CSUM] = bad_csum;
      fin_stat[RXFS_ST_MISALIGN] = misalign;
      fin_stat[RXFS_ST_DROPPED] = dropped;
      // ok only with all error bits clear
      fin_stat[RXFS_ST_OK] = !bad_csum && !misalign && !dropped &&
                             !st_ff.result[RXFS_ST_OVERFLOW];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.dma.take = 1'b0;
      nxt_st.dma.reject = 1'b0;
      nxt_st.dma.stat_wr = 1'b0;
      nxt_st.tinc = '0;
      nxt_st.slverr = 1'b0;
      // Pin synchronisers
      nxt_st.car_sync = {st_ff.car_sync[0], carrier_present_input_i};
      nxt_st.col_sync = {st_ff.col_sync[0], collision_line_i};
      // deferral tracks synchronised carrier or collision
      nxt_st.result[RXFS_ST_DEFER] = st_ff.car_sync[1] ||
                                     st_ff.col_sync[1];
      nxt_st.result[RXFS_ST_RX_OFF] = st_ff.cfg[RXFS_CFG_OBSERVE];

      // APB: one wait state, ready pulses for one edge
      nxt_st.ready = apb_acc && !st_ff.ready;
      if (apb_wr) begin
         // page zero 0x0c write is the config
         if (paddr_i == RXFS_OFS_FILTER) begin
            if (!page0) begin
               nxt_st.slverr = 1'b1;
            end else if (pstrb_i[0]) begin
               nxt_st.cfg = {2'b00, pwdata_i[5:0]};
            end
         end else if (paddr_i == RXFS_OFS_ADDR_LO) begin
            for (int b = 0; b < 4; b++) begin
               if (pstrb_i[b]) nxt_st.station[b*8 +: 8] = pwdata_i[b*8 +: 8];
            end
         end else if (paddr_i == RXFS_OFS_ADDR_HI) begin
            if (pstrb_i[0]) nxt_st.station[39:32] = pwdata_i[7:0];
            if (pstrb_i[1]) nxt_st.station[47:40] = pwdata_i[15:8];
         end else if (paddr_i == RXFS_OFS_HASH_LO) begin
            for (int b = 0; b < 4; b++) begin
               if (pstrb_i[b]) nxt_st.hash[b*8 +: 8] = pwdata_i[b*8 +: 8];
            end
         end else if (paddr_i == RXFS_OFS_HASH_HI) begin
            for (int b = 0; b < 4; b++) begin
               if (pstrb_i[b]) nxt_st.hash[32+b*8 +: 8] = pwdata_i[b*8 +: 8];
            end
         end else if (paddr_i == RXFS_OFS_PAGE) begin
            if (pstrb_i[0]) nxt_st.page = pwdata_i[1:0];
         end else if (paddr_i != RXFS_OFS_TALLY) begin
            nxt_st.slverr = 1'b1;
         end
      end
      if (apb_rd) begin
         // page zero 0x0c read is the status
         if (paddr_i == RXFS_OFS_RESULT && page0) begin
            nxt_st.rdata = {24'h000000, st_ff.result};
         end else if (paddr_i == RXFS_OFS_ADDR_LO) begin
            nxt_st.rdata = st_ff.station[31:0];
         end else if (paddr_i == RXFS_OFS_ADDR_HI) begin
            nxt_st.rdata = {16'h0000, st_ff.station[47:32]};
         end else if (paddr_i == RXFS_OFS_HASH_LO) begin
            nxt_st.rdata = st_ff.hash[31:0];
         end else if (paddr_i == RXFS_OFS_HASH_HI) begin
            nxt_st.rdata = st_ff.hash[63:32];
         end else if (paddr_i == RXFS_OFS_TALLY) begin
            nxt_st.rdata = {8'h00, dropped_cnt, checksum_cnt, misalign_cnt};
         end else if (paddr_i == RXFS_OFS_PAGE) begin
            nxt_st.rdata = {30'h0, st_ff.page};
         end else begin
            nxt_st.rdata = 32'h00000000;
            nxt_st.slverr = 1'b1;
         end
      end

      // Frame sequencer
      case (st_ff.fsm)
         RXFS_IDLE: begin
            if (rx_i.start) begin
               // clear frame bits as the next frame starts
               nxt_st.result[5:0] = 6'h00;
               nxt_st.da_idx = 3'h0;
               nxt_st.crc = 32'hffffffff;
               nxt_st.len = 16'h0000;
               nxt_st.accept = 1'b0;
               nxt_st.recognised = 1'b0;
               nxt_st.fsm = RXFS_DEST;
            end
         end
         RXFS_DEST: begin
            if (rx_i.valid) begin
               nxt_st.len = st_ff.len + 16'h0001;
               nxt_st.crc = crc_new;
               nxt_st.da[st_ff.da_idx*8 +: 8] = byte_in;
               nxt_st.da_idx = st_ff.da_idx + 3'h1;
               if (st_ff.da_idx == RXFS_DA_LAST) begin
                  nxt_st.recognised = uni_hit || grp_hit;
                  nxt_st.accept = (uni_hit || grp_hit) &&
                                  !st_ff.cfg[RXFS_CFG_OBSERVE] &&
                                  !rx_i.no_buffer;
                  nxt_st.result[RXFS_ST_GROUP] = grp_hit;
                  nxt_st.fsm = RXFS_BODY;
               end
            end
            // Too short to hold an address: nothing recognised
            if (rx_i.done) nxt_st.fsm = RXFS_IDLE;
         end
         RXFS_BODY: begin
            if (rx_i.valid) nxt_st.len = st_ff.len + 16'h0001;
            if (rx_i.fifo_over && st_ff.accept) begin
               nxt_st.result[RXFS_ST_OVERFLOW] = 1'b1;
               nxt_st.result[RXFS_ST_OK] = 1'b0;
               nxt_st.dma.reject = 1'b1;
               nxt_st.fsm = RXFS_DROP;
            end else if (rx_i.done) begin
               nxt_st.result = fin_stat;
               nxt_st.tinc.checksum = bad_csum;
               nxt_st.tinc.misalign = misalign;
               // observe mode counts each recognised frame
               nxt_st.tinc.dropped = dropped;
               if (st_ff.accept && !err_rej) begin
                  // status byte at head of kept frame
                  nxt_st.dma.take = 1'b1;
                  nxt_st.dma.stat_wr = 1'b1;
                  nxt_st.dma.stat = fin_stat;
               end else if (st_ff.accept) begin
                  nxt_st.dma.reject = 1'b1;
               end
               nxt_st.fsm = RXFS_IDLE;
            end
         end
         RXFS_DROP: begin
            // Rest of aborted frame is discarded
            if (rx_i.done) nxt_st.fsm = RXFS_IDLE;
         end
         default: nxt_st.fsm = RXFS_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o = st_ff.rdata;
   assign pready_o = st_ff.ready;
   assign pslverr_o = st_ff.slverr;
   assign dma_o = st_ff.dma;
endmodule

// >>> rxfs_filter_monitor.sv
// Port checker for the receive frame filter.
// Assumes it is bound onto rxfs_filter and sees only its ports.
`timescale 1ns/100ps
module rxfs_checker
   import rxfs_pkg::*;
(
   // Clock, reset and bus handshake
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Stream in, result out
   input wire rxfs_pkg::rxfs_stream_t rx_i,
   input wire rxfs_pkg::rxfs_dma_t dma_o
);
   // One domain, so one clocking and one disable
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_pulse; pready_o |=> !pready_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");
   property p_err; pslverr_o |-> pready_o; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_take; dma_o.take |-> $past(rx_i.done); endproperty
   a_take: assert property (p_take) else $error("take not after end");
   property p_stat; dma_o.stat_wr |-> dma_o.take; endproperty
   a_stat: assert property (p_stat) else $error("status unheaded");
   property p_head; dma_o.take |-> dma_o.stat_wr; endproperty
   a_head: assert property (p_head) else $error("no status head");
   property p_ok; dma_o.stat_wr && dma_o.stat[0] |-> dma_o.stat[4:1] == 4'h0;
   endproperty
   a_ok: assert property (p_ok) else $error("ok with error");
   property p_align; dma_o.stat_wr && dma_o.stat[2] |-> dma_o.stat[1];
   endproperty
   a_align: assert property (p_align) else $error("no crc on align");
   property p_excl; dma_o.take |-> !dma_o.reject; endproperty
   a_excl: assert property (p_excl) else $error("take and reject");
   // Main scenarios reached
   c_good: cover property (dma_o.take && dma_o.stat[0]);
   c_align: cover property (dma_o.stat_wr && dma_o.stat[2]);
   c_err: cover property (pslverr_o);
   c_reject: cover property (dma_o.reject);
endmodule
bind rxfs_filter rxfs_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .rx_i(rx_i), .dma_o(dma_o));

// >>> rxfs_line_model.sv
// Line decoder stand-in sending decoded frames byte by byte.
// Assumes the filter samples rx_o on the rising edge of clk_i.
`timescale 1ns/100ps
module rxfs_line_model
   import rxfs_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Decoded stream
   output rxfs_pkg::rxfs_stream_t rx_o
);
   initial rx_o = '0;
   // Destination first, first byte in bits 7:0; gap slows delivery
   // ovf pulses the FIFO overflow at byte 10; nob holds no buffer left
   task automatic send(input logic [47:0] da, input int len,
      input logic [2:0] drb, input logic bad, input logic gap,
      input logic ovf, input logic nob);
      @(posedge clk_i);
      rx_o.start <= 1'b1;
      rx_o.no_buffer <= nob;
      for (int i = 0; i < len; i++) begin
         @(posedge clk_i);
         rx_o.start <= 1'b0;
         rx_o.valid <= 1'b1;
         rx_o.data <= (i < 6) ? da[8*i +: 8] : 8'(i);
         rx_o.fifo_over <= ovf && i == 10;
         if (gap) begin
            @(posedge clk_i);
            rx_o.valid <= 1'b0;
            rx_o.fifo_over <= 1'b0;
         end
      end
      @(posedge clk_i);
      rx_o.valid <= 1'b0;
      rx_o.fifo_over <= 1'b0;
      rx_o.data <= ~rx_o.data;
      rx_o.done <= 1'b1;
      rx_o.dribble <= drb;
      rx_o.csum_bad_end <= bad;
      rx_o.csum_bad_byte <= bad;
      // End qualifiers are void now, so never leave them stale
      @(posedge clk_i);
      rx_o.done <= 1'b0;
      rx_o.no_buffer <= 1'b0;
      rx_o.dribble <= ~drb;
      rx_o.csum_bad_end <= ~bad;
      rx_o.csum_bad_byte <= ~bad;
   endtask
endmodule

// >>> rx_frame_filter_status_tb_top.sv
// Self-checking bench: APB master, line model and random frames.
// Assumes the design, the line model and the checker are compiled.
`timescale 1ns/100ps
module rx_frame_filter_status_tb_top;
   import rxfs_pkg::*;
   localparam logic [47:0] STA = 48'h0a09_0807_0604;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, err, took, rej, bad, h;
   logic carrier_present_input_i = 1'b0;
   logic collision_line_i = 1'b0;
   logic [5:0] c;
   logic [2:0] drb;
   rxfs_stream_t rx_i;
   rxfs_dma_t dma_o;
   int err_count = 0;
   int n_compared = 0;
   int seed = 32'h751c6582;
   int k, len;
   int lens[6] = '{7, 8, 20, 63, 64, 90};
   rxfs_filter uut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
      .carrier_present_input_i(carrier_present_input_i),
      .collision_line_i(collision_line_i), .dma_o(dma_o));
   rxfs_line_model u_line (.clk_i(clk_i), .rx_o(rx_i));
   initial forever #5 clk_i = ~clk_i;
   // Latch any take or reject pulse of the current frame
   always @(posedge clk_i) if (dma_o.take === 1'b1) took <= 1'b1;
   always @(posedge clk_i) if (dma_o.reject === 1'b1) rej <= 1'b1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1) begin
         check(0, 1);
         close_out();
      end
   endtask
   function automatic logic [47:0] da_of(input int kk);
      case (kk)
         0: return 48'hffff_ffff_ffff;
         1: return 48'h6655_4433_2203;
         2: return STA;
         default: return STA ^ 48'h08;
      endcase
   endfunction
   // Kinds: 0 all ones, 1 group, 2 own station, 3 other unicast
   function automatic logic exp_take(input logic [5:0] cf, input int kk,
      input int ln, input logic bd, input logic hs);
      logic m;
      m = kk == 0 ? cf[2] : kk == 1 ? cf[3] & hs : kk == 2 ? 1'b1 : cf[4];
      return m && !cf[5] && (!bd || cf[0]) && (ln >= 64 || (cf[1] && ln >= 8));
   endfunction
   task automatic frame(input logic [5:0] cf, input int kk, input int ln,
      input logic bd, input logic hs, input logic [2:0] dr);
      logic e;
      e = exp_take(cf, kk, ln, bd, hs);
      apb(1, RXFS_OFS_FILTER, {26'h0, cf});
      apb(1, RXFS_OFS_HASH_LO, {32{hs}});
      apb(1, RXFS_OFS_HASH_HI, {32{hs}});
      took = 1'b0;
      rej = 1'b0;
      u_line.send(da_of(kk), ln, dr, bd, 1'($random(seed)), 1'b0, 1'b0);
      repeat (3) @(posedge clk_i);
      check(took, e);
      check(rej, exp_take(cf, kk, 64, 1'b0, hs) && !e);
      if (e) check(dma_o.stat, {2'b0, kk < 2, 2'b0, dr > 0, bd, !bd});
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd, 32'h0);
      apb(1, RXFS_OFS_ADDR_LO, STA[31:0]);
      apb(1, RXFS_OFS_ADDR_HI, {16'h0, STA[47:32]});
      apb(0, 12'h030, 0);
      check(err, 1'b1);
      apb(1, RXFS_OFS_PAGE, 32'h1);
      apb(0, RXFS_OFS_RESULT, 0);
      check(err, 1'b1);
      apb(1, RXFS_OFS_PAGE, 32'h0);
      $display("test regs done");
      apb(1, RXFS_OFS_TALLY, 0);
      frame(6'h01, 2, 70, 1'b1, 1'b0, 3'h6);
      apb(0, RXFS_OFS_TALLY, 0);
      check(rd, 32'h101);
      apb(1, RXFS_OFS_TALLY, 0);
      frame(6'h20, 2, 70, 1'b0, 1'b0, 3'h0);
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd, 32'h50);
      apb(0, RXFS_OFS_TALLY, 0);
      check(rd, 32'h10000);
      $display("test observe done");
      carrier_present_input_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd[7], 1'b1);
      carrier_present_input_i <= 1'b0;
      collision_line_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd[7], 1'b1);
      collision_line_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      $display("test deferral done");
      // Overflow aborts a taken frame and leaves the tallies alone
      apb(1, RXFS_OFS_FILTER, 0);
      apb(1, RXFS_OFS_TALLY, 0);
      took = 1'b0;
      rej = 1'b0;
      u_line.send(STA, 70, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge clk_i);
      check({took, rej}, 2'b01);
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd, 32'h08);
      // No buffer left: dropped and counted, never taken
      rej = 1'b0;
      u_line.send(STA, 70, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge clk_i);
      check({took, rej}, 2'b00);
      apb(0, RXFS_OFS_RESULT, 0);
      check(rd, 32'h10);
      apb(0, RXFS_OFS_TALLY, 0);
      check(rd, 32'h10000);
      $display("test buffer done");
      for (int i = 0; i < 60; i++) begin
         k = $unsigned($random(seed)) % 4;
         c = 6'($random(seed));
         h = 1'($random(seed));
         if (k == 0) c[3] = 1'b0;
         bad = ($unsigned($random(seed)) % 4) == 0;
         drb = (bad && $random(seed) % 2) ? 3'h6 : 3'h0;
         len = lens[$unsigned($random(seed)) % 6];
         frame(c, k, len, bad, h, drb);
      end
      $display("test random done");
      close_out();
   end
endmodule
